// [core/iofs_top.sv]
// internal oscillator frequency select: control register, source mux control and pll gating
// ----------------------------------------
// How it works
// - fast postscaler and slow osc share one mux
// - four-bit field picks the mux frequency
// - any reset loads select with 0111
// - duplicate codes; same-source switch is faster
// - pll times four gives 32 mhz
// - pll mode needs internal osc config type
// - pll mode needs clock source select 00
// - pll mode needs select code 1110
// - pll on by soft or config bit
// - config bit locks pll, no plain 8mhz
// - source select 1x keeps pll out
// ----------------------------------------
//
// The register addresses and the Wishbone interface to the registers were chosen for this implementation.
`timescale 1ns/1ps
`default_nettype none

module iofs_top
  import iofs_pkg::*;
#(
  parameter int ADR_W = 4
) (
  // clock and reset
  input wire logic clock,
  input wire logic rst,
  // wishbone classic slave
  input wire logic wb_cyc_i,
  input wire logic wb_stb_i,
  input wire logic wb_we_i,
  input wire logic [ADR_W-1:0] wb_adr_i,
  input wire logic [31:0] wb_dat_i,
  input wire logic [3:0] wb_sel_i,
  output logic [31:0] wb_dat_o,
  output logic wb_ack_o,
  // configuration word levels
  input wire logic [2:0] config_osc_type,
  input wire logic config_pll_enable,
  // clock mux control
  output iofs_sel_s mux_sel,
  output logic mux_switching,
  output logic pll_enable,
  output logic [1:0] clock_source_out
);

  // ----------------------------------------
  // control register
  // ----------------------------------------
  logic [3:0] freq_select; // chosen frequency code
  logic [1:0] clock_source_select; // system clock source
  logic soft_pll_enable; // software pll request
  logic bus_req; // new request this cycle
  logic bus_wr; // new write with low byte lane

  assign bus_req = wb_cyc_i && wb_stb_i && !wb_ack_o;
  assign bus_wr = bus_req && wb_we_i && wb_sel_i[0];

  // register writes, reset returns to 500 khz
  always_ff @(posedge clock) begin
    if (rst) begin
      freq_select <= FREQ_RESET;
      clock_source_select <= CSS_RESET;
      soft_pll_enable <= 1'b0;
    end else if (bus_wr && wb_adr_i[3:0] == OSC_CTRL_OFS) begin
      freq_select <= wb_dat_i[FSEL_LSB +: 4];
      clock_source_select <= wb_dat_i[CSS_LSB +: 2];
      soft_pll_enable <= wb_dat_i[SPLL_BIT];
    end
  end

  // ----------------------------------------
  // target selection
  // ----------------------------------------
  logic pll_req; // pll wanted by either bit
  logic want_pll; // every pll condition met
  iofs_sel_s target_sel; // selection the mux should reach

  // config bit forces pll on, software cannot clear it
  assign pll_req = soft_pll_enable || config_pll_enable;

  // pll only on internal type, css 00, code 1110
  assign want_pll = pll_req
    && config_osc_type == OSC_TYPE_INTERNAL
    && clock_source_select == CSS_CONFIG
    && freq_select == FREQ_PLL_CODE;

  // pll path overrides the plain 8 mhz tap
  always_comb begin
    target_sel = iofs_decode(freq_select);
    if (want_pll) begin
      target_sel = '{src: SRC_PLL, div_exp: 4'h0};
    end
  end

  // ----------------------------------------
  // mux switch sequencer
  // ----------------------------------------
  typedef enum logic {ST_IDLE, ST_SWITCH} iofs_state_e;
  iofs_state_e state; // sequencer state
  logic [CNT_W-1:0] wait_cnt; // cycles left in switch
  iofs_sel_s pending_sel; // selection being moved to
  logic start_sw; // a change is accepted now
  logic same_src; // change stays on one source

  assign start_sw = state == ST_IDLE && target_sel != mux_sel;
  assign same_src = target_sel.src == mux_sel.src;

  // state and wait counter; the mux moves only when the wait is over
  always_ff @(posedge clock) begin
    if (rst) begin
      state <= ST_IDLE;
      wait_cnt <= '0;
      pending_sel <= SEL_RESET;
    end else begin
      case (state)
        ST_IDLE: begin
          if (start_sw) begin
            state <= ST_SWITCH;
            pending_sel <= target_sel;
            // same source retunes quickly, new source waits longer
            if (same_src) begin
              wait_cnt <= CNT_W'(SAME_SWITCH_CYC - 1);
            end else begin
              wait_cnt <= CNT_W'(SRC_SWITCH_CYC - 1);
            end
          end
        end
        ST_SWITCH: begin
          if (wait_cnt == '0) begin
            state <= ST_IDLE;
          end else begin
            wait_cnt <= wait_cnt - 1'b1;
          end
        end
        default: begin
          state <= ST_IDLE;
        end
      endcase
    end
  end

  // mux control outputs; one selection drives the single mux
  always_ff @(posedge clock) begin
    if (rst) begin
      mux_sel <= SEL_RESET;
      mux_switching <= 1'b0;
    end else begin
      if (start_sw) begin
        mux_switching <= 1'b1;
      end else if (state == ST_SWITCH && wait_cnt == '0) begin
        mux_sel <= pending_sel;
        mux_switching <= 1'b0;
      end
    end
  end

  // pll enable and source select to the system clock switch
  always_ff @(posedge clock) begin
    if (rst) begin
      pll_enable <= 1'b0;
      clock_source_out <= CSS_RESET;
    end else begin
      pll_enable <= pll_req;
      clock_source_out <= clock_source_select;
    end
  end

  // ----------------------------------------
  // bus answer
  // ----------------------------------------
  // one-cycle ack; unmapped reads return zero
  always_ff @(posedge clock) begin
    if (rst) begin
      wb_ack_o <= 1'b0;
      wb_dat_o <= '0;
    end else begin
      wb_ack_o <= bus_req;
      wb_dat_o <= '0;
      if (bus_req && !wb_we_i) begin
        if (wb_adr_i[3:0] == OSC_CTRL_OFS) begin
          wb_dat_o[FSEL_LSB +: 4] <= freq_select;
          wb_dat_o[CSS_LSB +: 2] <= clock_source_select;
          wb_dat_o[SPLL_BIT] <= soft_pll_enable;
        end else if (wb_adr_i[3:0] == OSC_STAT_OFS) begin
          wb_dat_o[ST_BUSY_BIT] <= mux_switching;
          wb_dat_o[ST_SRC_LSB +: 2] <= mux_sel.src;
          wb_dat_o[ST_DIV_LSB +: 4] <= mux_sel.div_exp;
          wb_dat_o[ST_PLL_BIT] <= pll_enable;
        end
      end
    end
  end

  // ----------------------------------------
  // checks
  // ----------------------------------------
  // reset restores 500 khz code and selection
  reset_default_a: assert property (@(posedge clock)
    rst |=> freq_select == 4'h7 && mux_sel == SEL_RESET && !mux_switching)
    else $error("reset did not restore the 500 khz selection");

  // mux takes the pending selection as the wait ends
  mux_apply_a: assert property (@(posedge clock) disable iff (rst)
    $fell(mux_switching) |-> mux_sel == $past(pending_sel))
    else $error("mux did not take the pending selection");

  // same-source change lasts exactly five cycles
  same_src_fast_a: assert property (@(posedge clock) disable iff (rst)
    (start_sw && same_src) |=> mux_switching[*5] ##1 !mux_switching)
    else $error("same source switch has wrong length");

  // source change is held longer than a retune
  new_src_slow_a: assert property (@(posedge clock) disable iff (rst)
    (start_sw && !same_src) |=> mux_switching[*8])
    else $error("source change ended too soon");

  // code zero always selects the slow oscillator
  slow_code_a: assert property (@(posedge clock) disable iff (rst)
    freq_select == 4'h0 |-> target_sel.src == SRC_SLOW)
    else $error("code zero did not pick the slow oscillator");

  // pll path only with all its conditions
  pll_gate_a: assert property (@(posedge clock) disable iff (rst)
    target_sel.src == SRC_PLL |-> config_osc_type == 3'h4
      && clock_source_select == 2'h0 && freq_select == 4'he && pll_req)
    else $error("pll path taken without its conditions");

  // source select 1x never reaches the pll
  css_block_a: assert property (@(posedge clock) disable iff (rst)
    clock_source_select[1] |-> target_sel.src != SRC_PLL)
    else $error("pll used with source select 1x");

  // config bit holds the pll on whatever software writes
  pll_lock_a: assert property (@(posedge clock) disable iff (rst)
    (!rst && config_pll_enable) |=> pll_enable)
    else $error("pll dropped while config bit set");

  // software bit alone turns the pll on
  soft_pll_a: assert property (@(posedge clock) disable iff (rst)
    $rose(soft_pll_enable) |=> pll_enable)
    else $error("software pll bit ignored");

  // 8 mhz code with pll conditions never gives plain 8 mhz
  no_plain_8m_a: assert property (@(posedge clock) disable iff (rst)
    (want_pll && !mux_switching && state == ST_IDLE) |=> mux_sel.src == SRC_PLL || mux_switching)
    else $error("plain 8 mhz kept while pll selected");

  // bus ack lasts one cycle
  bus_ack_a: assert property (@(posedge clock) disable iff (rst)
    bus_req |=> wb_ack_o ##1 !wb_ack_o)
    else $error("bus ack not a single cycle");

  // mux selection only moves as a switch completes
  mux_hold_a: assert property (@(posedge clock) disable iff (rst)
    !(state == ST_SWITCH && wait_cnt == '0) |=> $stable(mux_sel))
    else $error("mux selection moved outside a switch end");

  // with neither bit set the pll is off
  pll_follow_a: assert property (@(posedge clock) disable iff (rst)
    (!rst && !soft_pll_enable && !config_pll_enable) |=> !pll_enable)
    else $error("pll on without any enable bit");

  // source select output copies the register
  css_copy_a: assert property (@(posedge clock) disable iff (rst)
    !rst |=> clock_source_out == $past(clock_source_select))
    else $error("source select output does not follow register");

  // read data is zero outside the ack cycle
  ack_data_a: assert property (@(posedge clock) disable iff (rst)
    !wb_ack_o |-> wb_dat_o == '0)
    else $error("read data not zero without ack");

  // wait counter never exceeds the longer wait
  wait_bound_a: assert property (@(posedge clock) disable iff (rst)
    state == ST_SWITCH |-> wait_cnt < CNT_W'(SRC_SWITCH_CYC))
    else $error("switch wait counter out of range");

  // accepted control write loads the select field
  ctrl_write_a: assert property (@(posedge clock) disable iff (rst)
    (!rst && bus_wr && wb_adr_i[3:0] == OSC_CTRL_OFS) |=> freq_select == $past(wb_dat_i[FSEL_LSB +: 4]))
    else $error("control write did not load the select field");

  // refused accesses leave the select field alone
  refused_write_a: assert property (@(posedge clock) disable iff (rst)
    (!rst && bus_req && !(wb_we_i && wb_sel_i[0] && wb_adr_i[3:0] == OSC_CTRL_OFS)) |=> $stable(freq_select))
    else $error("select field changed by a refused access");

  // only code zero reaches the slow oscillator
  slow_src_a: assert property (@(posedge clock) disable iff (rst)
    target_sel.src == SRC_SLOW |-> freq_select == 4'h0)
    else $error("slow oscillator picked by a nonzero code");

  // an accepted change raises the switching flag next cycle
  switch_start_a: assert property (@(posedge clock) disable iff (rst)
    (!rst && start_sw) |=> mux_switching)
    else $error("switch accepted but flag not raised");

endmodule

`default_nettype wire

// [core/iofs_pkg.sv]
// shared constants, types and code table for the internal oscillator frequency select
package iofs_pkg;

  // ----------------------------------------
  // clock and timing
  // ----------------------------------------
  localparam int CLK_PERIOD_NS = 10; // 100 mhz core clock
  localparam int SAME_SWITCH_NS = 50; // retune within one source
  localparam int SRC_SWITCH_NS = 2000; // hand over to another source
  // least times, rounded up to whole cycles
  localparam int SAME_SWITCH_CYC = (SAME_SWITCH_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam int SRC_SWITCH_CYC = (SRC_SWITCH_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam int CNT_W = 8; // wide enough for the longer wait

  // ----------------------------------------
  // register map
  // ----------------------------------------
  localparam logic [3:0] OSC_CTRL_OFS = 4'h0; // osc_control_reg
  localparam logic [3:0] OSC_STAT_OFS = 4'h4; // active selection status
  // osc_control_reg fields
  localparam int CSS_LSB = 0; // clock_source_select, 2 bits
  localparam int FSEL_LSB = 3; // freq_select, 4 bits
  localparam int SPLL_BIT = 7; // soft_pll_enable
  // status fields
  localparam int ST_BUSY_BIT = 0;
  localparam int ST_SRC_LSB = 1;
  localparam int ST_DIV_LSB = 3;
  localparam int ST_PLL_BIT = 7;

  // ----------------------------------------
  // reset values and encodings
  // ----------------------------------------
  localparam logic [3:0] FREQ_RESET = 4'h7; // 500 khz
  localparam logic [3:0] FREQ_PLL_CODE = 4'he; // 8 mhz fast osc, pll input
  localparam logic [1:0] CSS_RESET = 2'h0;
  localparam logic [1:0] CSS_CONFIG = 2'h0; // use config_osc_type clock
  localparam logic [2:0] OSC_TYPE_INTERNAL = 3'h4;

  // ----------------------------------------
  // types
  // ----------------------------------------
  typedef enum logic [1:0] {SRC_SLOW, SRC_MID, SRC_FAST, SRC_PLL} iofs_src_e; // mux inputs

  typedef struct packed {
    iofs_src_e src; // which oscillator feeds the mux
    logic [3:0] div_exp; // postscaler divide is 2**div_exp
  } iofs_sel_s;

  localparam iofs_sel_s SEL_RESET = '{src: SRC_FAST, div_exp: 4'h5}; // 16 mhz / 32

  // code table: fast osc is 16 mhz, mid tap 500 khz, slow osc 31 khz
  function automatic iofs_sel_s iofs_decode(input logic [3:0] code);
    iofs_sel_s s;
    s = '{src: SRC_FAST, div_exp: 4'h0};
    case (code)
      4'h0: s = '{src: SRC_SLOW, div_exp: 4'h0}; // 31 khz
      4'h1: s = '{src: SRC_FAST, div_exp: 4'h9}; // 31.25 khz
      4'h2: s = '{src: SRC_MID, div_exp: 4'h4}; // 31.25 khz
      4'h3: s = '{src: SRC_MID, div_exp: 4'h3}; // 62.5 khz
      4'h4: s = '{src: SRC_MID, div_exp: 4'h2}; // 125 khz
      4'h5: s = '{src: SRC_MID, div_exp: 4'h1}; // 250 khz
      4'h6: s = '{src: SRC_MID, div_exp: 4'h0}; // 500 khz
      4'h7: s = '{src: SRC_FAST, div_exp: 4'h5}; // 500 khz
      4'h8: s = '{src: SRC_FAST, div_exp: 4'h8}; // 62.5 khz
      4'h9: s = '{src: SRC_FAST, div_exp: 4'h7}; // 125 khz
      4'ha: s = '{src: SRC_FAST, div_exp: 4'h6}; // 250 khz
      4'hb: s = '{src: SRC_FAST, div_exp: 4'h4}; // 1 mhz
      4'hc: s = '{src: SRC_FAST, div_exp: 4'h3}; // 2 mhz
      4'hd: s = '{src: SRC_FAST, div_exp: 4'h2}; // 4 mhz
      4'he: s = '{src: SRC_FAST, div_exp: 4'h1}; // 8 mhz
      default: s = '{src: SRC_FAST, div_exp: 4'h0}; // 16 mhz
    endcase
    return s;
  endfunction

endpackage

// [tb/tb_top.sv]
// self-checking bench for the internal oscillator frequency select block
`timescale 1ns/1ps
`default_nettype none

module tb_top;
  import iofs_pkg::*;
  // ----------------------------------------
  // stimulus and observation signals
  // ----------------------------------------
  logic clock = 1'b0;
  logic rst = 1'b1;
  logic cyc = 1'b0, stb = 1'b0, we = 1'b0; // wishbone request
  logic [3:0] adr = 4'h0, sel = 4'h0;
  logic [31:0] wdat = 32'h0, rdat, got;
  logic ack, switching, pll_on;
  logic [2:0] osc = 3'h0; // config levels
  logic cpll = 1'b0;
  iofs_sel_s msel, prev;
  logic [1:0] css_out;
  logic [3:0] cur_code = FREQ_RESET; // code now held in the register
  int n_errors = 0, comparisons = 0, n;

  always #5 clock = ~clock; // 100 mhz

  iofs_top #(.ADR_W(4)) dut (.clock(clock), .rst(rst), .wb_cyc_i(cyc), .wb_stb_i(stb), .wb_we_i(we),
    .wb_adr_i(adr), .wb_dat_i(wdat), .wb_sel_i(sel), .wb_dat_o(rdat), .wb_ack_o(ack),
    .config_osc_type(osc), .config_pll_enable(cpll), .mux_sel(msel), .mux_switching(switching),
    .pll_enable(pll_on), .clock_source_out(css_out));

  // ----------------------------------------
  // shared tasks
  // ----------------------------------------
  task automatic check(input logic [31:0] seen, input logic [31:0] exp);
    comparisons++;
    if (seen !== exp) begin
      n_errors++;
      $display("wrong value at %0t: seen %h expected %h", $time, seen, exp);
    end
  endtask

  // one classic cycle; holds until ack is sampled, then releases
  task automatic wb_cycle(input logic w, input logic [3:0] a, input logic [7:0] d, input logic [3:0] s);
    @(posedge clock);
    cyc <= 1'b1;
    stb <= 1'b1;
    we <= w;
    adr <= a;
    wdat <= {24'h0, d};
    sel <= s;
    @(posedge clock);
    while (ack !== 1'b1) @(posedge clock);
    got = rdat;
    cyc <= 1'b0;
    stb <= 1'b0;
    we <= 1'b0;
  endtask

  task automatic print_verdict;
    $display("counts: %0d comparisons, %0d mismatches", comparisons, n_errors);
    if (n_errors == 0 && comparisons > 0) $display("ALL TESTS PASSED");
    else $display("TESTS FAILED");
    $finish;
  endtask

  // expected mux selection from control byte and config levels
  function automatic iofs_sel_s exp_sel(input logic [7:0] c, input logic [2:0] o, input logic cp);
    logic [3:0] k;
    k = c[6:3];
    if ((c[7] | cp) && o == OSC_TYPE_INTERNAL && c[1:0] == CSS_CONFIG && k == FREQ_PLL_CODE)
      return '{src: SRC_PLL, div_exp: 4'h0};
    if (k == 4'h0) return '{src: SRC_SLOW, div_exp: 4'h0};
    if (k >= 4'h2 && k <= 4'h6) return '{src: SRC_MID, div_exp: 4'h6 - k};
    case (k)
      4'h1: return '{src: SRC_FAST, div_exp: 4'h9};
      4'h7: return '{src: SRC_FAST, div_exp: 4'h5};
      4'h8: return '{src: SRC_FAST, div_exp: 4'h8};
      4'h9: return '{src: SRC_FAST, div_exp: 4'h7};
      4'ha: return '{src: SRC_FAST, div_exp: 4'h6};
      default: return '{src: SRC_FAST, div_exp: 4'hf - k};
    endcase
  endfunction

  // config change (only off the pll code), control write, then timed switch check
  task automatic step(input logic [7:0] c, input logic [2:0] o, input logic cp);
    iofs_sel_s e;
    if (cur_code != FREQ_PLL_CODE) begin
      osc <= o;
      cpll <= cp;
      repeat (2) @(posedge clock);
    end
    wb_cycle(1'b1, OSC_CTRL_OFS, c, 4'h1);
    cur_code = c[6:3];
    e = exp_sel(c, osc, cpll);
    n = 0;
    #1;
    while (switching === 1'b1 && n < 400) begin
      n++;
      @(posedge clock);
      #1;
    end
    check(n, (e == prev) ? 0 : (e.src == prev.src) ? SAME_SWITCH_CYC : SRC_SWITCH_CYC);
    check(msel, e);
    check(pll_on, c[7] | cpll);
    check(css_out, c[1:0]);
    prev = e;
    wb_cycle(1'b0, OSC_STAT_OFS, 8'h0, 4'hf);
    check(got, {24'h0, c[7] | cpll, e.div_exp, e.src, 1'b0});
  endtask

  // ----------------------------------------
  // watchdog
  // ----------------------------------------
  initial begin
    #1000000;
    n_errors++;
    print_verdict();
  end

  // ----------------------------------------
  // main sequence
  // ----------------------------------------
  initial begin
    logic [31:0] r;
    void'($urandom(32'ha018b362));
    prev = SEL_RESET;
    repeat (5) @(posedge clock);
    rst <= 1'b0;
    @(posedge clock);
    check(msel, SEL_RESET);
    wb_cycle(1'b0, OSC_CTRL_OFS, 8'h0, 4'hf);
    check(got, 32'h38);
    $display("test reset done");
    // every code, plain sources
    for (int k = 0; k < 16; k++) step({1'b0, 4'(k), 3'h0}, 3'h4, 1'b0);
    $display("test code sweep done");
    // pll corners: soft, css 1x, wrong type, config lock
    step(8'hf0, 3'h0, 1'b0);
    step(8'h08, 3'h4, 1'b0);
    step(8'hf0, 3'h4, 1'b0);
    step(8'hf2, 3'h4, 1'b0);
    step(8'h73, 3'h4, 1'b0);
    step(8'h08, 3'h3, 1'b0);
    step(8'h70, 3'h3, 1'b0);
    step(8'h08, 3'h4, 1'b1);
    step(8'h70, 3'h4, 1'b1);
    step(8'h71, 3'h4, 1'b1);
    $display("test pll done");
    // refused accesses leave control unchanged
    step(8'h48, 3'h4, 1'b0);
    wb_cycle(1'b1, OSC_STAT_OFS, 8'hff, 4'hf);
    wb_cycle(1'b1, 4'h8, 8'hff, 4'hf);
    wb_cycle(1'b1, OSC_CTRL_OFS, 8'h00, 4'he);
    wb_cycle(1'b0, 4'h8, 8'h0, 4'hf);
    check(got, 32'h0);
    wb_cycle(1'b0, OSC_CTRL_OFS, 8'h0, 4'hf);
    check(got, 32'h48);
    $display("test refused done");
    // random mix of codes, sources and pll settings
    for (int i = 0; i < 24; i++) begin
      r = $urandom;
      step(r[7:0] & 8'hfb, r[8] ? 3'h4 : r[11:9], r[12]);
    end
    $display("test random done");
    // second reset in the middle of a long switch
    wb_cycle(1'b1, OSC_CTRL_OFS, (cur_code == 4'h0) ? 8'h08 : 8'h00, 4'h1);
    repeat (3) @(posedge clock);
    check(switching, 1'b1);
    rst <= 1'b1;
    repeat (5) @(posedge clock);
    rst <= 1'b0;
    @(posedge clock);
    check(msel, SEL_RESET);
    check(switching, 1'b0);
    wb_cycle(1'b0, OSC_CTRL_OFS, 8'h0, 4'hf);
    check(got, 32'h38);
    $display("test second reset done");
    print_verdict();
  end
endmodule

`default_nettype wire
